// *** rtl/eesm_pkg.sv ***
// Package for the encoder echo and speed match block: register map, resets, limits, carriers
package eesm_pkg;

  // Bus geometry
  localparam int ADDR_W = 14;
  localparam int DATA_W = 32;

  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_PPR = 12'h15c;
  localparam logic [11:0] IDX_SMT = 12'h15e;
  localparam logic [11:0] IDX_GDEN = 12'h180;
  localparam logic [11:0] IDX_CTRL = 12'h181;
  localparam logic [11:0] IDX_SPD_CMD = 12'h182;
  localparam logic [11:0] IDX_SPD_LIMIT = 12'h183;
  localparam logic [11:0] IDX_STATUS = 12'h184;
  localparam logic [11:0] IDX_MASK = 12'h185;
  localparam logic [11:0] IDX_LIVE = 12'h186;
  localparam logic [11:0] IDX_GNUM0 = 12'h188;

  // Reset values
  localparam logic [31:0] PPR_RST = 32'h0000_09c4;
  localparam logic [15:0] SMT_RST = 16'h000a;
  localparam logic [31:0] GDEN_RST = 32'h0000_000a;
  localparam logic [31:0] GNUM_RST = 32'h0000_0010;
  localparam logic [15:0] SPD_LIMIT_RST = 16'h1388;

  // Accepted ranges
  localparam logic [31:0] PPR_MIN = 32'h0000_0004;
  localparam logic [31:0] PPR_MAX = 32'h0000_9c40;
  localparam logic [15:0] SMT_MAX = 16'h012c;
  localparam logic [31:0] GNUM_MAX = 32'h03ff_ffff;
  localparam logic [47:0] RATIO_LO_DEN = 48'h0000_0000_0032;
  localparam logic [47:0] RATIO_HI_NUM = 48'h0000_0000_6400;

  // Control bit positions
  localparam int CTRL_PT_MODE = 0;
  localparam int CTRL_SCALE_X4 = 1;
  localparam int CTRL_SRC_REG = 2;
  localparam int CTRL_ALARM_CLR = 3;
  localparam int CTRL_W = 3;

  // Status bit positions, shared by the mask
  localparam int ST_ALARM = 0;
  localparam int ST_REFUSED = 1;
  localparam int ST_MATCH = 2;
  localparam int ST_W = 3;

  // Index pulse timing
  localparam int CLK_NS = 40;
  localparam int MIN_INDEX_NS = 250000;
  localparam int MIN_INDEX_CYC = (MIN_INDEX_NS + CLK_NS - 1) / CLK_NS;

  // Speed update from the speed loop
  typedef struct packed {
    logic valid;
    logic signed [15:0] analog_cmd;
    logic signed [15:0] feedback;
  } eesm_speed_t;

  // Emulated encoder output lines
  typedef struct packed {
    logic phase_a;
    logic phase_b;
    logic index;
  } eesm_enc_t;

endpackage : eesm_pkg

// *** rtl/eesm_core.sv ***
// Encoder echo, gear denominator guard, pulse frequency alarm and speed match output
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// R1 - Software must keep every gear numerator over the denominator strictly between 1/50 and 25600.
// R2 - A gear denominator write is refused while the servo is on in pulse position mode.
// R3 - The encoder output pulse count per revolution accepts 4 to 40000 and resets to 2500.
// R4 - The output scale select treats that count as single-phase pulses or as the total after times-4 counting.
// R5 - The index pulse lasts the computed width, but never less than 250 us.
// R6 - The pulse frequency alarm rises on an encoder fault, an output overrun or a speed above the limit.
// R7 - The speed match output is high while the absolute speed error is below the threshold.
// R8 - A zero threshold holds the speed match output low.
// R9 - The compared command is the raw user command from the analog input or a register.
// R10 - The compared feedback is the filtered motor speed.
// R11 - The threshold accepts 0 to 300 and resets to 10.
// R12 - Exactly one index pulse per revolution, aligned with the revolution start.
// R13 - The compare runs on every speed-loop update and the output follows in that update.
module eesm_core #(
  parameter int MOT_CPR = 10000,
  parameter int MIN_IDX_CYC = eesm_pkg::MIN_INDEX_CYC
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // APB slave
  input wire logic [eesm_pkg::ADDR_W-1:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [eesm_pkg::DATA_W-1:0] pwdata_in,
  output logic [eesm_pkg::DATA_W-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Drive state and speed loop
  input wire logic servo_on_in,
  input wire eesm_pkg::eesm_speed_t speed_in,
  // Motor encoder pins
  input wire logic mot_count_in,
  input wire logic mot_dir_in,
  input wire logic mot_index_in,
  input wire logic enc_fault_in,
  // Outputs to the host controller
  output eesm_pkg::eesm_enc_t enc_out,
  output logic speed_match_output_out,
  output logic pulse_frequency_alarm_out,
  output logic irq_out
);

  // Elaboration checks
  if (MOT_CPR < 1 || MOT_CPR > 1000000)
    $error("MOT_CPR out of range");
  if (MIN_IDX_CYC < 1 || MIN_IDX_CYC > 16000000)
    $error("MIN_IDX_CYC out of range");

  localparam logic [31:0] CPR = 32'(MOT_CPR);
  localparam logic [25:0] MIN_W = 26'(MIN_IDX_CYC);

  // Absolute speed error
  function automatic logic [16:0] abs_diff(input logic signed [15:0] a, input logic signed [15:0] b);
    logic signed [16:0] d;
    d = 17'(signed'({a[15], a})) - 17'(signed'({b[15], b}));
    return d[16] ? 17'(-d) : 17'(d);
  endfunction : abs_diff

  logic [31:0] ppr_q;
  logic [15:0] smt_q;
  logic [31:0] gden_q;
  logic [31:0] gnum_q [4];
  localparam int CTRL_W_L = eesm_pkg::CTRL_W;
  logic [CTRL_W_L-1:0] ctrl_q;
  logic signed [15:0] spd_cmd_q;
  logic [15:0] spd_limit_q;
  logic [eesm_pkg::ST_W-1:0] status_q;
  logic [eesm_pkg::ST_W-1:0] mask_q;
  logic [eesm_pkg::ST_W-1:0] ev;
  logic [31:0] prdata_q;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [3:0] sync3_q;
  logic [31:0] acc_q;
  logic [1:0] quad_q;
  logic [23:0] per_cnt_q;
  logic [23:0] per_q;
  logic [25:0] idx_cnt_q;
  logic alarm_q;
  logic match_q;
  logic [3:0] ratio_ok;

  //////////////////////////////////////////////////////////////////////////////
  // APB decode

  logic [11:0] idx;
  logic access;
  logic setup;
  logic wr;
  logic err;
  logic refused_gden;
  logic mapped;
  logic [2:0] gnum_sel;
  logic gnum_hit;
  assign idx = paddr_in[13:2];
  assign setup = psel_in & ~penable_in;
  assign access = psel_in & penable_in;
  assign pready_out = 1'b1;
  assign gnum_sel = 3'(idx - eesm_pkg::IDX_GNUM0);
  // Exact numerator window; the narrow select alone would alias higher indices
  assign gnum_hit = idx >= eesm_pkg::IDX_GNUM0 && idx <= eesm_pkg::IDX_GNUM0 + 12'h3;

  // Mapped addresses
  always_comb
  begin
    mapped = (paddr_in[1:0] == 2'b00) && (idx == eesm_pkg::IDX_PPR || idx == eesm_pkg::IDX_SMT ||
             idx == eesm_pkg::IDX_GDEN || idx == eesm_pkg::IDX_CTRL || idx == eesm_pkg::IDX_SPD_CMD ||
             idx == eesm_pkg::IDX_SPD_LIMIT || idx == eesm_pkg::IDX_STATUS || idx == eesm_pkg::IDX_MASK ||
             idx == eesm_pkg::IDX_LIVE || gnum_hit);
  end

  // Refusals: locked denominator and out-of-range values
  assign refused_gden = pwrite_in && idx == eesm_pkg::IDX_GDEN && servo_on_in
                        && ctrl_q[eesm_pkg::CTRL_PT_MODE]; // R2
  always_comb
  begin
    err = !mapped || refused_gden;
    if (pwrite_in)
    begin
      if (idx == eesm_pkg::IDX_PPR && (pwdata_in < eesm_pkg::PPR_MIN || pwdata_in > eesm_pkg::PPR_MAX))
        err = 1'b1; // R3
      if (idx == eesm_pkg::IDX_SMT && pwdata_in > 32'(eesm_pkg::SMT_MAX))
        err = 1'b1; // R11
      if (idx == eesm_pkg::IDX_GDEN && (pwdata_in == 32'h0 || pwdata_in[31]))
        err = 1'b1;
      if (gnum_hit && (pwdata_in == 32'h0 || pwdata_in > eesm_pkg::GNUM_MAX))
        err = 1'b1;
    end
  end
  assign pslverr_out = access & err;
  assign wr = access & pwrite_in & ~err;

  // Configuration registers
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ppr_q <= eesm_pkg::PPR_RST; // R3
      smt_q <= eesm_pkg::SMT_RST; // R11
      gden_q <= eesm_pkg::GDEN_RST;
      ctrl_q <= '0;
      spd_cmd_q <= '0;
      spd_limit_q <= eesm_pkg::SPD_LIMIT_RST;
      mask_q <= '0;
    end
    else if (wr)
    begin
      unique case (idx)
        eesm_pkg::IDX_PPR: ppr_q <= pwdata_in;
        eesm_pkg::IDX_SMT: smt_q <= pwdata_in[15:0];
        eesm_pkg::IDX_GDEN: gden_q <= pwdata_in; // R2
        eesm_pkg::IDX_CTRL: ctrl_q <= pwdata_in[CTRL_W_L-1:0];
        eesm_pkg::IDX_SPD_CMD: spd_cmd_q <= pwdata_in[15:0];
        eesm_pkg::IDX_SPD_LIMIT: spd_limit_q <= pwdata_in[15:0];
        eesm_pkg::IDX_MASK: mask_q <= pwdata_in[eesm_pkg::ST_W-1:0];
        default: ;
      endcase
    end
  end

  // Gear numerators and ratio check per numerator
  for (genvar i = 0; i < 4; i++)
  begin : g_gnum
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
      if (rst_in)
        gnum_q[i] <= eesm_pkg::GNUM_RST;
      else if (wr && idx == eesm_pkg::IDX_GNUM0 + 12'(i))
        gnum_q[i] <= pwdata_in;
    end
    assign ratio_ok[i] = (48'(gnum_q[i]) * eesm_pkg::RATIO_LO_DEN > 48'(gden_q))
                         && (48'(gnum_q[i]) < 48'(gden_q) * eesm_pkg::RATIO_HI_NUM); // R1
  end

  // Read data, captured in the setup phase
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      prdata_q <= '0;
    else if (setup)
    begin
      prdata_q <= '0;
      if (gnum_hit)
        prdata_q <= gnum_q[gnum_sel[1:0]];
      else if (mapped)
      begin
        unique case (idx)
          eesm_pkg::IDX_PPR: prdata_q <= ppr_q;
          eesm_pkg::IDX_SMT: prdata_q <= 32'(smt_q);
          eesm_pkg::IDX_GDEN: prdata_q <= gden_q;
          eesm_pkg::IDX_CTRL: prdata_q <= 32'(ctrl_q);
          eesm_pkg::IDX_SPD_CMD: prdata_q <= 32'({16'h0, spd_cmd_q});
          eesm_pkg::IDX_SPD_LIMIT: prdata_q <= 32'(spd_limit_q);
          eesm_pkg::IDX_STATUS: prdata_q <= 32'(status_q | ev); // Setup-cycle events are reported before the clear
          eesm_pkg::IDX_MASK: prdata_q <= 32'(mask_q);
          eesm_pkg::IDX_LIVE: prdata_q <= {26'h0, &ratio_ok, idx_cnt_q != 26'h0, servo_on_in, alarm_q,
                                           speed_match_output_out, 1'b0};
          default: ;
        endcase
      end
    end
  end
  assign prdata_out = prdata_q;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: count, dir, index, fault

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end
    else
    begin
      sync1_q <= {enc_fault_in, mot_index_in, mot_dir_in, mot_count_in};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  logic cnt_evt;
  logic idx_evt;
  logic fault_s;
  assign cnt_evt = sync2_q[0] & ~sync3_q[0];
  assign idx_evt = sync2_q[2] & ~sync3_q[2];
  assign fault_s = sync2_q[3];

  //////////////////////////////////////////////////////////////////////////////
  // Encoder echo: rate multiplier from motor counts to quadrature edges

  logic [31:0] incr;
  logic [32:0] acc_sum;
  logic step;
  logic overrun;
  assign incr = ctrl_q[eesm_pkg::CTRL_SCALE_X4] ? ppr_q : {ppr_q[29:0], 2'b00}; // R4
  assign acc_sum = 33'(acc_q) + 33'(incr);
  assign step = cnt_evt && acc_sum >= 33'(CPR);
  assign overrun = cnt_evt && acc_sum >= 33'({CPR, 1'b0}); // R6

  // Accumulator, reset at the revolution start to align the index
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      acc_q <= '0;
    else if (idx_evt)
      acc_q <= '0; // R12
    else if (step)
      acc_q <= 32'(acc_sum - 33'(CPR));
    else if (cnt_evt)
      acc_q <= acc_sum[31:0];
  end

  // Quadrature state, gray sequence on phase a and b
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      quad_q <= '0;
    else if (step)
      quad_q <= sync2_q[1] ? quad_q - 2'h1 : quad_q + 2'h1;
  end

  // Edge period measurement for the computed index width
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      per_cnt_q <= '0;
      per_q <= '0; // No period measured yet: minimum index width
    end
    else if (step)
    begin
      per_cnt_q <= '0;
      per_q <= per_cnt_q;
    end
    else if (per_cnt_q != 24'hff_ffff)
      per_cnt_q <= per_cnt_q + 24'h1;
  end

  // Index pulse: one per revolution, four edge periods or the minimum
  logic [25:0] calc_w;
  assign calc_w = {per_q, 2'b00};
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      idx_cnt_q <= '0;
    else if (idx_evt && idx_cnt_q == 26'h0)
      idx_cnt_q <= (calc_w > MIN_W) ? calc_w : MIN_W; // R5 R12
    else if (idx_cnt_q != 26'h0)
      idx_cnt_q <= idx_cnt_q - 26'h1;
  end

  assign enc_out.phase_a = quad_q[1];
  assign enc_out.phase_b = quad_q[1] ^ quad_q[0];
  assign enc_out.index = idx_cnt_q != 26'h0;

  //////////////////////////////////////////////////////////////////////////////
  // Pulse frequency alarm, latched until cleared through control

  logic [15:0] fb_abs;
  logic over_speed;
  logic alarm_set;
  logic alarm_clr;
  assign fb_abs = speed_in.feedback[15] ? 16'(-speed_in.feedback) : speed_in.feedback;
  assign over_speed = speed_in.valid && spd_limit_q != 16'h0 && fb_abs > spd_limit_q;
  assign alarm_set = fault_s | overrun | over_speed; // R6
  assign alarm_clr = wr && idx == eesm_pkg::IDX_CTRL && pwdata_in[eesm_pkg::CTRL_ALARM_CLR];
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      alarm_q <= 1'b0;
    else if (alarm_set)
      alarm_q <= 1'b1; // R6
    else if (alarm_clr)
      alarm_q <= 1'b0;
  end
  assign pulse_frequency_alarm_out = alarm_q;

  //////////////////////////////////////////////////////////////////////////////
  // Speed match on every speed-loop update

  logic signed [15:0] cmd_sel;
  logic [16:0] err_abs;
  assign cmd_sel = ctrl_q[eesm_pkg::CTRL_SRC_REG] ? spd_cmd_q : speed_in.analog_cmd; // R9
  assign err_abs = abs_diff(cmd_sel, speed_in.feedback); // R10
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      match_q <= 1'b0;
    else if (speed_in.valid)
      match_q <= smt_q != 16'h0 && err_abs < 17'(smt_q); // R7 R13
  end
  assign speed_match_output_out = match_q && smt_q != 16'h0; // R8

  //////////////////////////////////////////////////////////////////////////////
  // Sticky status, cleared by reading it; a new event wins over the clear

  logic match_prev_q;
  logic rd_clr;
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      match_prev_q <= 1'b0;
    else
      match_prev_q <= speed_match_output_out;
  end
  always_comb
  begin
    ev = '0;
    ev[eesm_pkg::ST_ALARM] = alarm_set & ~alarm_q;
    ev[eesm_pkg::ST_REFUSED] = access & refused_gden; // R2
    ev[eesm_pkg::ST_MATCH] = speed_match_output_out & ~match_prev_q;
  end
  assign rd_clr = access && !pwrite_in && idx == eesm_pkg::IDX_STATUS && mapped;
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      status_q <= '0;
    else
      status_q <= (rd_clr ? '0 : status_q) | ev;
  end
  assign irq_out = |(status_q & mask_q);

  //////////////////////////////////////////////////////////////////////////////
  // Assertions

  logic [25:0] z_len_q;
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      z_len_q <= '0;
    else if (enc_out.index)
      z_len_q <= z_len_q + 26'h1;
    else
      z_len_q <= '0;
  end

  AST_GDEN_LOCK: assert property (@(posedge core_clk_in) disable iff (rst_in) // R2
    access && refused_gden |=> $stable(gden_q) && status_q[eesm_pkg::ST_REFUSED])
    else $error("denominator changed while locked");
  AST_PPR_RANGE: assert property (@(posedge core_clk_in) disable iff (rst_in) // R3
    ppr_q >= eesm_pkg::PPR_MIN && ppr_q <= eesm_pkg::PPR_MAX)
    else $error("pulse count out of range");
  AST_SCALE: assert property (@(posedge core_clk_in) disable iff (rst_in) // R4
    !ctrl_q[eesm_pkg::CTRL_SCALE_X4] |-> incr == {ppr_q[29:0], 2'b00})
    else $error("single phase scale wrong");
  AST_INDEX_MIN: assert property (@(posedge core_clk_in) disable iff (rst_in) // R5
    $fell(enc_out.index) |-> z_len_q >= MIN_W)
    else $error("index pulse too short");
  AST_INDEX_CAUSE: assert property (@(posedge core_clk_in) disable iff (rst_in) // R12
    $rose(enc_out.index) |-> $past(idx_evt) && acc_q == 32'h0)
    else $error("index without revolution start");
  AST_ALARM: assert property (@(posedge core_clk_in) disable iff (rst_in) // R6
    fault_s |=> pulse_frequency_alarm_out ##1 (pulse_frequency_alarm_out || $past(alarm_clr)))
    else $error("alarm missing on encoder fault");
  AST_MATCH: assert property (@(posedge core_clk_in) disable iff (rst_in) // R7
    speed_in.valid && smt_q != 16'h0 && err_abs < 17'(smt_q) && !$changed(smt_q)
    ##1 $stable(smt_q) |-> speed_match_output_out)
    else $error("speed match not raised");
  AST_ZERO: assert property (@(posedge core_clk_in) disable iff (rst_in) // R8
    smt_q == 16'h0 |-> !speed_match_output_out)
    else $error("speed match high with zero threshold");
  AST_SRC: assert property (@(posedge core_clk_in) disable iff (rst_in) // R9
    speed_in.valid && ctrl_q[eesm_pkg::CTRL_SRC_REG] && abs_diff(spd_cmd_q, speed_in.feedback) >= 17'(smt_q)
    |=> !match_q)
    else $error("register command not used");
  AST_FB: assert property (@(posedge core_clk_in) disable iff (rst_in) // R10
    speed_in.valid && cmd_sel == speed_in.feedback && smt_q != 16'h0 |=> match_q)
    else $error("feedback not compared");
  AST_HOLD: assert property (@(posedge core_clk_in) disable iff (rst_in) // R13
    !speed_in.valid |=> $stable(match_q))
    else $error("match changed outside update");

  COV_INDEX: cover property (@(posedge core_clk_in) disable iff (rst_in) $fell(enc_out.index));
  COV_MATCH: cover property (@(posedge core_clk_in) disable iff (rst_in) $rose(speed_match_output_out));
  COV_REFUSE: cover property (@(posedge core_clk_in) disable iff (rst_in) access && refused_gden);
  COV_IRQ: cover property (@(posedge core_clk_in) disable iff (rst_in) $rose(irq_out));

endmodule : eesm_core

`default_nettype wire

// *** bench/eesm_host_model.sv ***
// Host controller model: decodes the emulated encoder and times the index pulse
`timescale 1ns/10ps
`default_nettype none

module eesm_host_model (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Lines from the drive
  input wire eesm_pkg::eesm_enc_t enc_in,
  // Decoded results
  output logic signed [31:0] pos_out,
  output logic [15:0] idx_cnt_out,
  output logic [15:0] idx_width_out
);
  logic [1:0] ab_q;
  logic idx_q;
  logic [15:0] run_q;

  ////////////////////////////////////////////////////////////////////////
  // Quadrature decode: forward when old a differs from new b
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ab_q <= 2'h0;
      pos_out <= 32'sh0;
    end
    else
    begin
      ab_q <= {enc_in.phase_a, enc_in.phase_b};
      if ({enc_in.phase_a, enc_in.phase_b} != ab_q)
        pos_out <= (ab_q[1] ^ enc_in.phase_b) ? pos_out + 32'sh1 : pos_out - 32'sh1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Index pulses counted and their width measured in clocks
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      idx_q <= 1'h0;
      run_q <= 16'h0;
      idx_cnt_out <= 16'h0;
      idx_width_out <= 16'h0;
    end
    else
    begin
      idx_q <= enc_in.index;
      run_q <= enc_in.index ? run_q + 16'h1 : 16'h0;
      if (enc_in.index && !idx_q)
        idx_cnt_out <= idx_cnt_out + 16'h1;
      if (!enc_in.index && idx_q)
        idx_width_out <= run_q;
    end
  end
endmodule : eesm_host_model

`default_nettype wire

// *** bench/encoder_echo_speed_match_tb.sv ***
// Testbench: registers, gear guard, encoder echo, alarm, interrupt and speed match
`timescale 1ns/10ps
`default_nettype none

module encoder_echo_speed_match_tb;
  logic clk = 1'h0, rst = 1'h1, psel = 1'h0, pen = 1'h0, pwr = 1'h0, servo = 1'h0;
  logic cnt_p = 1'h0, dir_p = 1'h0, idx_p = 1'h0, flt_p = 1'h0;
  logic [13:0] paddr = 14'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, match, alarm, irq;
  eesm_pkg::eesm_speed_t spd_v = '0;
  eesm_pkg::eesm_enc_t enc;
  logic signed [31:0] pos, p0;
  logic [15:0] icnt, iwid;
  int miscompares = 0, n_checks = 0;

  always #20 clk = ~clk;

  eesm_core #(.MOT_CPR(100), .MIN_IDX_CYC(8)) u_eesm_core (.core_clk_in(clk), .rst_in(rst),
    .paddr_in(paddr), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .servo_on_in(servo),
    .speed_in(spd_v), .mot_count_in(cnt_p), .mot_dir_in(dir_p), .mot_index_in(idx_p),
    .enc_fault_in(flt_p), .enc_out(enc), .speed_match_output_out(match),
    .pulse_frequency_alarm_out(alarm), .irq_out(irq));

  eesm_host_model u_eesm_host_model (.core_clk_in(clk), .rst_in(rst), .enc_in(enc),
    .pos_out(pos), .idx_cnt_out(icnt), .idx_width_out(iwid));

  ////////////////////////////////////////////////////////////////////////
  // Verdict and compares
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize

  task chk32(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk32

  task chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk1

  ////////////////////////////////////////////////////////////////////////
  // APB master: setup, access until pready, then release
  task apb(input logic w, input logic [11:0] idx, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    pen <= 1'h0;
    pwr <= w;
    paddr <= {idx, 2'h0};
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'h1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'h1 && n < 50);
    if (n >= 50)
    begin
      miscompares++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask : apb

  task wr(input logic [11:0] idx, input logic [31:0] d, input logic e);
    apb(1'h1, idx, d);
    chk1(err, e);
  endtask : wr

  task rdc(input logic [11:0] idx, input logic [31:0] d, input logic e);
    apb(1'h0, idx, 32'h0);
    chk1(err, e);
    chk32(rd, d);
  endtask : rdc

  ////////////////////////////////////////////////////////////////////////
  // Pin and speed-loop stimulus
  task spd(input logic signed [15:0] c, input logic signed [15:0] f);
    @(posedge clk);
    spd_v <= {1'h1, c, f};
    @(posedge clk);
    spd_v.valid <= 1'h0;
    #1;
  endtask : spd

  task pulses(input int k);
    repeat (k)
    begin
      @(posedge clk);
      cnt_p <= 1'h1;
      repeat (4) @(posedge clk);
      cnt_p <= 1'h0;
      repeat (3) @(posedge clk);
    end
    repeat (8) @(posedge clk);
  endtask : pulses

  task index_rev;
    int n;
    @(posedge clk);
    idx_p <= 1'h1;
    repeat (6) @(posedge clk);
    idx_p <= 1'h0;
    n = 0;
    while (enc.index !== 1'h0 && n < 20000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 20000)
    begin
      miscompares++;
      summarize();
    end
    repeat (3) @(posedge clk);
  endtask : index_rev

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    rdc(eesm_pkg::IDX_PPR, 32'h9c4, 1'h0);
    rdc(eesm_pkg::IDX_SMT, 32'ha, 1'h0);
    rdc(eesm_pkg::IDX_GDEN, 32'ha, 1'h0);
    rdc(12'h100, 32'h0, 1'h1);
    rdc(12'h190, 32'h0, 1'h1);
    rdc(eesm_pkg::IDX_LIVE, 32'h20, 1'h0);
    wr(eesm_pkg::IDX_GNUM0 + 12'h3, 32'h3ff_ffff, 1'h0);
    rdc(eesm_pkg::IDX_LIVE, 32'h0, 1'h0);
    // Range edges of pulse count and threshold
    wr(eesm_pkg::IDX_PPR, 32'h3, 1'h1);
    wr(eesm_pkg::IDX_PPR, 32'h9c41, 1'h1);
    wr(eesm_pkg::IDX_PPR, 32'h4, 1'h0);
    wr(eesm_pkg::IDX_PPR, 32'h9c40, 1'h0);
    rdc(eesm_pkg::IDX_PPR, 32'h9c40, 1'h0);
    wr(eesm_pkg::IDX_SMT, 32'h12d, 1'h1);
    wr(eesm_pkg::IDX_SMT, 32'h12c, 1'h0);
    rdc(eesm_pkg::IDX_SMT, 32'h12c, 1'h0);
    // Denominator guarded while on in pulse position mode; masked then unmasked
    servo <= 1'h1;
    wr(eesm_pkg::IDX_CTRL, 32'h1, 1'h0);
    wr(eesm_pkg::IDX_GDEN, 32'h14, 1'h1);
    chk1(irq, 1'h0);
    rdc(eesm_pkg::IDX_STATUS, 32'h2, 1'h0);
    wr(eesm_pkg::IDX_MASK, 32'h2, 1'h0);
    wr(eesm_pkg::IDX_GDEN, 32'h14, 1'h1);
    #1;
    chk1(irq, 1'h1);
    rdc(eesm_pkg::IDX_STATUS, 32'h2, 1'h0);
    #1;
    chk1(irq, 1'h0);
    rdc(eesm_pkg::IDX_GDEN, 32'ha, 1'h0);
    servo <= 1'h0;
    wr(eesm_pkg::IDX_GDEN, 32'h14, 1'h0);
    rdc(eesm_pkg::IDX_GDEN, 32'h14, 1'h0);
    // Speed match boundaries, absolute value, zero threshold, command source
    wr(eesm_pkg::IDX_CTRL, 32'h0, 1'h0);
    wr(eesm_pkg::IDX_SMT, 32'ha, 1'h0);
    spd(16'sd100, 16'sd91);
    chk1(match, 1'h1);
    spd(-16'sd5, 16'sd5);
    chk1(match, 1'h0);
    spd(16'sd5, -16'sd4);
    chk1(match, 1'h1);
    spd(16'sd50, 16'sd50);
    chk1(match, 1'h1);
    wr(eesm_pkg::IDX_SMT, 32'h0, 1'h0);
    spd(16'sd50, 16'sd50);
    chk1(match, 1'h0);
    wr(eesm_pkg::IDX_SMT, 32'ha, 1'h0);
    wr(eesm_pkg::IDX_SPD_CMD, 32'hc8, 1'h0);
    wr(eesm_pkg::IDX_CTRL, 32'h4, 1'h0);
    spd(16'sd0, 16'sd200);
    chk1(match, 1'h1);
    wr(eesm_pkg::IDX_CTRL, 32'h0, 1'h0);
    spd(16'sd0, 16'sd200);
    chk1(match, 1'h0);
    rdc(eesm_pkg::IDX_STATUS, 32'h4, 1'h0);
    // Encoder echo: ten counts, x4 total then single phase, index per revolution
    wr(eesm_pkg::IDX_PPR, 32'h14, 1'h0);
    wr(eesm_pkg::IDX_CTRL, 32'h2, 1'h0);
    index_rev();
    chk32({16'h0, icnt}, 32'h1);
    chk1(iwid >= 16'h8, 1'h1);
    p0 = pos;
    pulses(10);
    chk32(pos - p0, 32'h2);
    wr(eesm_pkg::IDX_CTRL, 32'h0, 1'h0);
    index_rev();
    chk32({16'h0, icnt}, 32'h2);
    chk1(iwid >= 16'h8, 1'h1);
    p0 = pos;
    pulses(10);
    chk32(pos - p0, 32'h8);
    chk1(alarm, 1'h0);
    // Alarm from encoder fault, then from overspeed, each cleared by software
    wr(eesm_pkg::IDX_MASK, 32'h1, 1'h0);
    @(posedge clk);
    flt_p <= 1'h1;
    repeat (6) @(posedge clk);
    flt_p <= 1'h0;
    repeat (4) @(posedge clk);
    chk1(alarm, 1'h1);
    chk1(irq, 1'h1);
    rdc(eesm_pkg::IDX_STATUS, 32'h1, 1'h0);
    wr(eesm_pkg::IDX_CTRL, 32'h8, 1'h0);
    #1;
    chk1(alarm, 1'h0);
    wr(eesm_pkg::IDX_SPD_LIMIT, 32'h64, 1'h0);
    spd(16'sd0, 16'sd100);
    @(posedge clk);
    #1;
    chk1(alarm, 1'h0);
    spd(16'sd0, 16'sd101);
    @(posedge clk);
    #1;
    chk1(alarm, 1'h1);
    wr(eesm_pkg::IDX_CTRL, 32'h8, 1'h0);
    rdc(eesm_pkg::IDX_STATUS, 32'h1, 1'h0);
    #1;
    chk1(irq, 1'h0);
    summarize();
  end
endmodule : encoder_echo_speed_match_tb

`default_nettype wire
